// ---- design/gain_offset_pkg.sv ----
// Constants, types and helpers shared by the gain/offset bank and its controller
package gain_offset_pkg;

  localparam int NUM_REGS = 16;
  localparam int ADC_W = 10;
  localparam int ERR_W = 12;

  // ----------------------------------------
  // Bank offsets
  // ----------------------------------------
  localparam logic [3:0] AMP_GAIN_0 = 4'h0;
  localparam logic [3:0] SIGNED_OFFSET_0 = 4'h4;
  localparam logic [3:0] PATTERN_LINE0_SELECT = 4'h8;
  localparam logic [3:0] PATTERN_LINE1_SELECT = 4'h9;
  localparam logic [3:0] PATTERN_LENGTH = 4'hA;
  localparam logic [3:0] BLACK_TARGET_CODE = 4'hB;
  localparam logic [3:0] CUSTOMER_CONTROL = 4'hC;
  localparam logic [3:0] ADVANCED_CONTROL = 4'hD;
  localparam logic [3:0] POWER_TRIM_A = 4'hE;
  localparam logic [3:0] POWER_TRIM_B = 4'hF;

  // Default contents, index equals offset
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h10, 8'h4E, 8'h00, 8'hAA, 8'h5A};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CUST_OUT_EN_BIT = 7;
  localparam int CUST_SER_OUT_BIT = 6;
  localparam int CUST_INTEG_LSB = 4;
  localparam int CUST_AUTOCAL_BIT = 3;
  localparam int TRIM_BANK_LSB = 4;
  localparam logic [7:0] LENGTH_MASK = 8'h0F;

  // ----------------------------------------
  // Timing and loop constants
  // ----------------------------------------
  localparam logic [4:0] CLAMP_ENGAGE_CYCLES = 5'd20;
  localparam logic [2:0] AVG_LAST = 3'd7;
  localparam int AVG_SHIFT = 3;
  localparam logic signed [ERR_W-1:0] OFFSET_MAX = 12'sd127;
  localparam logic signed [ERR_W-1:0] OFFSET_MIN = -12'sd128;

  // ----------------------------------------
  // Controller map (APB byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_CMD = 8'h00;
  localparam logic [7:0] CTRL_STATUS = 8'h04;
  localparam logic [7:0] CTRL_LINE = 8'h08;
  localparam logic [7:0] CTRL_CLAMP = 8'h0C;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_DATA_LSB = 8;

  typedef enum logic [1:0] {LINK_IDLE, LINK_ISSUE, LINK_WAIT} link_state_t;

  // Two-bit field idx of a byte, lowest field first
  function automatic logic [1:0] field2(input logic [7:0] word, input logic [1:0] idx);
    return word[{idx, 1'b0} +: 2];
  endfunction

endpackage

// ---- design/gain_offset_link_if.sv ----
// Link between the gain/offset bank and its controller
`timescale 1ns/100ps
interface gain_offset_link_if;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic line_start_strobe;
  logic black_clamp_strobe;

  modport dev_mp (
    input reg_wr,
    input reg_rd,
    input reg_addr,
    input reg_wdata,
    output reg_rdata,
    output reg_rvalid,
    input line_start_strobe,
    input black_clamp_strobe
  );

  modport host_mp (
    output reg_wr,
    output reg_rd,
    output reg_addr,
    output reg_wdata,
    input reg_rdata,
    input reg_rvalid,
    output line_start_strobe,
    output black_clamp_strobe
  );
endinterface

// ---- design/pattern_sequencer.sv ----
// Pixel-rate selector sequencer driven by the line-start strobe
`timescale 1ns/100ps
module pattern_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line_start_strobe,
  input wire logic [7:0] line0_word,
  input wire logic [7:0] line1_word,
  input wire logic [7:0] length_word,
  output logic [1:0] sel,
  output logic active
);
  import gain_offset_pkg::*;

  logic strobe_d_ff;
  logic started_ff;
  logic line_ff;
  logic nxt_line;
  logic [1:0] pos_ff;
  logic [1:0] nxt_pos;
  logic [1:0] use_pos;
  logic [1:0] last_pos;
  logic [1:0] sel_ff;
  logic active_ff;
  logic rise;

  assign rise = line_start_strobe & ~strobe_d_ff;

  always_comb
  begin
    nxt_line = (rise && started_ff) ? ~line_ff : line_ff;
    use_pos = rise ? 2'h0 : pos_ff;
    last_pos = field2(length_word, {1'b0, nxt_line});
    nxt_pos = (use_pos == last_pos) ? 2'h0 : use_pos + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe_d_ff <= 1'b0;
      started_ff <= 1'b0;
      line_ff <= 1'b0;
      pos_ff <= 2'h0;
    end
    else
    begin
      strobe_d_ff <= line_start_strobe;
      started_ff <= started_ff | rise;
      line_ff <= nxt_line;
      if (line_start_strobe)
        pos_ff <= nxt_pos;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_ff <= 2'h0;
      active_ff <= 1'b0;
    end
    else
    begin
      active_ff <= line_start_strobe;
      if (line_start_strobe)
        sel_ff <= field2(nxt_line ? line1_word : line0_word, use_pos);
    end
  end

  assign sel = sel_ff;
  assign active = active_ff;
endmodule

// ---- design/gain_offset_device.sv ----
// Configuration bank, pattern sequencer hookup and digital black-level loop
`timescale 1ns/100ps
module gain_offset_device (
  input wire logic pclk,
  input wire logic presetn,
  gain_offset_link_if.dev_mp link,
  input wire logic [gain_offset_pkg::ADC_W-1:0] adc_code,
  output logic [7:0] gain_code,
  output logic [7:0] offset_code,
  output logic pix_valid,
  output logic clamp_engaged,
  output logic offset_pinned,
  output logic offset_out_en,
  output logic [gain_offset_pkg::ERR_W-1:0] offset_err,
  output logic [7:0] customer_bits,
  output logic [7:0] advanced_bits,
  output logic [3:0] bank_power
);
  import gain_offset_pkg::*;

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  logic [7:0] regs_ff [NUM_REGS];
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic autocal;
  logic wr_blocked;
  logic loop_update;
  logic signed [ERR_W-1:0] nxt_acc;

  assign autocal = regs_ff[CUSTOMER_CONTROL][CUST_AUTOCAL_BIT];
  assign wr_blocked = autocal && (link.reg_addr[3:2] == SIGNED_OFFSET_0[3:2]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_ff[i] <= REG_RESET[i];
    end
    else
    begin
      if (link.reg_wr && !wr_blocked)
        regs_ff[link.reg_addr] <= (link.reg_addr == PATTERN_LENGTH) ?
          (link.reg_wdata & LENGTH_MASK) : link.reg_wdata;
      // Loop result lands in all four offsets so a read shows it
      if (loop_update && autocal)
        for (int k = 0; k < 4; k++)
          regs_ff[SIGNED_OFFSET_0 + 4'(k)] <= nxt_acc[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= link.reg_rd;
      // Serial output disabled reads back as zero
      if (link.reg_rd)
        rdata_ff <= regs_ff[CUSTOMER_CONTROL][CUST_SER_OUT_BIT] ?
          regs_ff[link.reg_addr] : 8'h00;
    end
  end

  assign link.reg_rdata = rdata_ff;
  assign link.reg_rvalid = rvalid_ff;

  // ----------------------------------------
  // Pixel-rate gain and offset selection
  // ----------------------------------------
  logic [1:0] sel;
  logic seq_active;
  logic [7:0] gain_ff;
  logic [7:0] offset_ff;
  logic pix_valid_ff;

  pattern_sequencer pattern_sequencer_inst (
    .pclk(pclk),
    .presetn(presetn),
    .line_start_strobe(link.line_start_strobe),
    .line0_word(regs_ff[PATTERN_LINE0_SELECT]),
    .line1_word(regs_ff[PATTERN_LINE1_SELECT]),
    .length_word(regs_ff[PATTERN_LENGTH]),
    .sel(sel),
    .active(seq_active)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_ff <= 8'h00;
      offset_ff <= 8'h00;
      pix_valid_ff <= 1'b0;
    end
    else
    begin
      gain_ff <= regs_ff[AMP_GAIN_0 + {2'b00, sel}];
      offset_ff <= regs_ff[SIGNED_OFFSET_0 + {2'b00, sel}];
      pix_valid_ff <= seq_active;
    end
  end

  // ----------------------------------------
  // Black clamp engage
  // ----------------------------------------
  logic [4:0] hi_cnt_ff;
  logic [4:0] nxt_hi_cnt;
  logic engaged_ff;

  always_comb
  begin
    if (!link.black_clamp_strobe)
      nxt_hi_cnt = 5'd0;
    else if (hi_cnt_ff == CLAMP_ENGAGE_CYCLES)
      nxt_hi_cnt = hi_cnt_ff;
    else
      nxt_hi_cnt = hi_cnt_ff + 5'd1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_cnt_ff <= 5'd0;
      engaged_ff <= 1'b0;
    end
    else
    begin
      hi_cnt_ff <= nxt_hi_cnt;
      engaged_ff <= link.black_clamp_strobe && (nxt_hi_cnt == CLAMP_ENGAGE_CYCLES);
    end
  end

  // ----------------------------------------
  // Averaging and offset integration
  // ----------------------------------------
  logic [ADC_W+2:0] sum_ff;
  logic [2:0] n_ff;
  logic [ADC_W+2:0] full_sum;
  logic signed [ERR_W-1:0] err;
  logic signed [ERR_W-1:0] step;
  logic signed [ERR_W-1:0] acc_ff;
  logic signed [ERR_W-1:0] raw_acc;
  logic signed [ERR_W-1:0] err_ff;
  logic pinned_ff;

  assign full_sum = sum_ff + {3'b000, adc_code};
  assign loop_update = engaged_ff && (n_ff == AVG_LAST);

  always_comb
  begin
    err = $signed({4'h0, regs_ff[BLACK_TARGET_CODE]}) -
      $signed({2'b00, full_sum[ADC_W+2:AVG_SHIFT]});
    unique case (regs_ff[CUSTOMER_CONTROL][CUST_INTEG_LSB +: 2])
      2'b00: step = err;
      2'b01: step = err >>> 2;
      2'b10: step = err >>> 3;
      2'b11: step = err >>> 4;
    endcase
    raw_acc = acc_ff + step;
    if (raw_acc > OFFSET_MAX)
      nxt_acc = OFFSET_MAX;
    else if (raw_acc < OFFSET_MIN)
      nxt_acc = OFFSET_MIN;
    else
      nxt_acc = raw_acc;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sum_ff <= '0;
      n_ff <= 3'd0;
    end
    else if (!engaged_ff || loop_update)
    begin
      sum_ff <= '0;
      n_ff <= 3'd0;
    end
    else
    begin
      sum_ff <= full_sum;
      n_ff <= n_ff + 3'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_ff <= '0;
      err_ff <= '0;
      pinned_ff <= 1'b0;
    end
    else if (loop_update && autocal)
    begin
      acc_ff <= nxt_acc;
      err_ff <= err;
      pinned_ff <= (raw_acc != nxt_acc);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign gain_code = gain_ff;
  assign offset_code = offset_ff;
  assign pix_valid = pix_valid_ff;
  assign clamp_engaged = engaged_ff;
  assign offset_pinned = pinned_ff;
  assign offset_out_en = regs_ff[CUSTOMER_CONTROL][CUST_OUT_EN_BIT];
  assign offset_err = err_ff;
  assign customer_bits = regs_ff[CUSTOMER_CONTROL];
  assign advanced_bits = regs_ff[ADVANCED_CONTROL];
  // bank power from upper trim bits
  assign bank_power = regs_ff[POWER_TRIM_B][TRIM_BANK_LSB +: 4];
endmodule

// ---- design/gain_offset_host.sv ----
// Controller: APB registers that drive the bank link and the line and clamp strobes
`timescale 1ns/100ps
module gain_offset_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  gain_offset_link_if.host_mp link
);
  import gain_offset_pkg::*;

  link_state_t state_ff;
  logic wr_ff;
  logic rd_ff;
  logic [3:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rback_ff;
  logic line_ff;
  logic clamp_req_ff;
  logic [4:0] hold_ff;
  logic clamp_ff;
  logic [31:0] prdata_ff;
  logic wr_access;
  logic cmd_go;

  assign wr_access = psel && penable && pwrite;
  assign cmd_go = wr_access && (paddr[7:0] == CTRL_CMD) && (state_ff == LINK_IDLE);

  // ----------------------------------------
  // Link command engine
  // ----------------------------------------
  // ordering left to software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= LINK_IDLE;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 4'h0;
      wdata_ff <= 8'h00;
      rback_ff <= 8'h00;
    end
    else
    begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      unique case (state_ff)
        LINK_IDLE:
          if (cmd_go)
          begin
            addr_ff <= pwdata[CMD_ADDR_LSB +: 4];
            wdata_ff <= pwdata[CMD_DATA_LSB +: 8];
            wr_ff <= pwdata[CMD_WRITE_BIT];
            rd_ff <= !pwdata[CMD_WRITE_BIT];
            state_ff <= LINK_ISSUE;
          end
        LINK_ISSUE:
          state_ff <= rd_ff ? LINK_WAIT : LINK_IDLE;
        LINK_WAIT:
          if (link.reg_rvalid)
          begin
            rback_ff <= link.reg_rdata;
            state_ff <= LINK_IDLE;
          end
      endcase
    end
  end

  // ----------------------------------------
  // Line and clamp strobes
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_ff <= 1'b0;
      clamp_req_ff <= 1'b0;
      hold_ff <= 5'd0;
      clamp_ff <= 1'b0;
    end
    else
    begin
      if (wr_access && paddr[7:0] == CTRL_LINE)
        line_ff <= pwdata[0];
      if (wr_access && paddr[7:0] == CTRL_CLAMP)
        clamp_req_ff <= pwdata[0];
      // strobe held at least twenty cycles
      if (wr_access && paddr[7:0] == CTRL_CLAMP && pwdata[0] && !clamp_req_ff)
        hold_ff <= CLAMP_ENGAGE_CYCLES;
      else if (hold_ff != 5'd0)
        hold_ff <= hold_ff - 5'd1;
      clamp_ff <= clamp_req_ff || (hold_ff != 5'd0);
    end
  end

  // ----------------------------------------
  // APB read path
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      unique case (paddr[7:0])
        CTRL_STATUS: prdata_ff <= {16'h0000, rback_ff, 7'h00, state_ff != LINK_IDLE};
        CTRL_LINE: prdata_ff <= {31'h0000_0000, line_ff};
        CTRL_CLAMP: prdata_ff <= {31'h0000_0000, clamp_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign link.reg_wr = wr_ff;
  assign link.reg_rd = rd_ff;
  assign link.reg_addr = addr_ff;
  assign link.reg_wdata = wdata_ff;
  assign link.line_start_strobe = line_ff;
  assign link.black_clamp_strobe = clamp_ff;
endmodule

// ---- verification/gain_offset_link_checker.sv ----
// Concurrent checks on the link between the controller and the gain/offset bank
`timescale 1ns/100ps
module gain_offset_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic line_start_strobe,
  input wire logic black_clamp_strobe
);
  logic [4:0] hi_cnt_ff;
  logic [7:0] tgt_ff;
  logic [7:0] cust_ff;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------
  // Shadows
  // ----------
  // Loop never rewrites these two, so link writes alone predict them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tgt_ff <= 8'h10;
      cust_ff <= 8'h4E;
    end
    else if (reg_wr && reg_addr == 4'hB)
      tgt_ff <= reg_wdata;
    else if (reg_wr && reg_addr == 4'hC)
      cust_ff <= reg_wdata;
  end

  // Consecutive high cycles of the clamp strobe, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_cnt_ff <= 5'h00;
    else if (!black_clamp_strobe)
      hi_cnt_ff <= 5'h00;
    else if (hi_cnt_ff != 5'h1F)
      hi_cnt_ff <= hi_cnt_ff + 5'h01;
  end

  // ----------
  // Assertions
  // ----------
  wr_single_a: assert property (reg_wr |=> !reg_wr)
    else $error("bank write pulse longer than one cycle");
  access_excl_a: assert property (!(reg_wr && reg_rd))
    else $error("bank read and write in the same cycle");
  rd_answer_a: assert property (reg_rd |=> reg_rvalid ##1 !reg_rvalid)
    else $error("bank read not answered by a single valid pulse");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a preceding read");
  clamp_hold_a: assert property ($fell(black_clamp_strobe) |-> hi_cnt_ff >= 5'd20)
    else $error("clamp strobe dropped before 20 cycles");
  length_nib_a: assert property (reg_rd && reg_addr == 4'hA |=> reg_rdata[7:4] == 4'h0)
    else $error("pattern length upper nibble not zero");
  target_rb_a: assert property (reg_rd && reg_addr == 4'hB |=>
    reg_rdata == (cust_ff[6] ? tgt_ff : 8'h00))
    else $error("black target read back wrong");
  ctrl_rb_a: assert property (reg_rd && reg_addr == 4'hC |=>
    reg_rdata == (cust_ff[6] ? cust_ff : 8'h00))
    else $error("customer control read back wrong");
endmodule

// ---- verification/cfa_gain_offset_config_bank_bench.sv ----
// Self-checking bench for the controller and gain/offset bank pair
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module cfa_gain_offset_config_bank_bench;
  import gain_offset_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [ADC_W-1:0] adc_code;
  logic [7:0] gain_code, offset_code, customer_bits, advanced_bits, b;
  logic pix_valid, clamp_engaged, offset_pinned, offset_out_en;
  logic [ERR_W-1:0] offset_err;
  logic [3:0] bank_power;
  int n_mismatch, total_checks, n;

  // ----------
  // Pair under test
  // ----------
  gain_offset_link_if link ();
  gain_offset_host gain_offset_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  gain_offset_device gain_offset_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .adc_code(adc_code), .gain_code(gain_code), .offset_code(offset_code),
    .pix_valid(pix_valid), .clamp_engaged(clamp_engaged), .offset_pinned(offset_pinned),
    .offset_out_en(offset_out_en), .offset_err(offset_err), .customer_bits(customer_bits),
    .advanced_bits(advanced_bits), .bank_power(bank_power));
  gain_offset_link_checker gain_offset_link_checker_inst (.pclk(pclk), .presetn(presetn),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid),
    .line_start_strobe(link.line_start_strobe),
    .black_clamp_strobe(link.black_clamp_strobe));

  // ----------
  // Bus and bank access
  // ----------
  // Opens on an edge of its own so back-to-back calls never reassign in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic bank(input logic wr, input logic [3:0] a, input logic [7:0] d);
    apb(1'b1, CTRL_CMD, {15'h0000, wr, d, 4'h0, a});
    do
      apb(1'b0, CTRL_STATUS, 32'h00000000);
    while (rd[0] !== 1'b0);
    b = rd[15:8];
  endtask

  task automatic expect_reg(input logic [3:0] a, input logic [7:0] e);
    bank(1'b0, a, 8'h00);
    `CHK("bank register", e, b)
  endtask

  task automatic wait_for(ref logic sig, input logic lvl);
    n = 0;
    while (sig !== lvl && n < 100)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic test_defaults();
    logic [7:0] dflt [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h10, 8'h4E, 8'h00, 8'hAA, 8'h5A};
    for (int i = 0; i < 16; i++)
      expect_reg(4'(i), dflt[i]);
    `CHK("bank power", 4'h5, bank_power)
    apb(1'b0, 8'h10, 32'h00000000);
    `CHK("unmapped read", 32'h00000000, rd)
    `CHK("slave error", 1'b0, pslverr)
    `CHK("slave ready", 1'b1, pready)
  endtask

  task automatic test_regs();
    bank(1'b1, 4'h4, 8'h7F);
    expect_reg(4'h4, 8'h00);
    bank(1'b1, 4'hC, 8'h46);
    bank(1'b1, 4'hD, 8'h35);
    bank(1'b1, 4'hF, 8'hC5);
    `CHK("customer bits", 8'h46, customer_bits)
    `CHK("advanced bits", 8'h35, advanced_bits)
    `CHK("bank power", 4'hC, bank_power)
    bank(1'b1, 4'h3, 8'hFF);
    expect_reg(4'h3, 8'hFF);
    bank(1'b1, 4'h7, 8'h80);
    expect_reg(4'h7, 8'h80);
    bank(1'b1, 4'hA, 8'hFD);
    expect_reg(4'hA, 8'h0D);
    bank(1'b1, 4'hB, 8'h25);
    expect_reg(4'hB, 8'h25);
    bank(1'b1, 4'hC, 8'h86);
    `CHK("offset out enable", 1'b1, offset_out_en)
    expect_reg(4'hB, 8'h00);
    bank(1'b1, 4'hC, 8'h46);
    bank(1'b1, 4'hF, 8'h5A);
  endtask

  task automatic run_line(input logic [1:0] s0, s1, s2, s3, input int len);
    logic [1:0] sq [4];
    sq = '{s0, s1, s2, s3};
    apb(1'b1, CTRL_LINE, 32'h00000001);
    wait_for(pix_valid, 1'b1);
    `CHK("line start", 1'b1, pix_valid)
    for (int i = 0; i < 12; i++)
    begin
      `CHK("pixel gain", 8'h11 * (sq[i % len] + 1), gain_code)
      `CHK("pixel offset", 8'hF1 + sq[i % len], offset_code)
      @(posedge pclk);
      #1;
    end
    apb(1'b1, CTRL_LINE, 32'h00000000);
    wait_for(pix_valid, 1'b0);
    `CHK("line end", 1'b0, pix_valid)
  endtask

  task automatic test_pattern();
    // gains and offsets, then line words, then length
    for (int i = 0; i < 4; i++)
    begin
      bank(1'b1, 4'(i), 8'(8'h11 * (i + 1)));
      bank(1'b1, 4'(i + 4), 8'(8'hF1 + i));
    end
    bank(1'b1, 4'h8, 8'h06);
    bank(1'b1, 4'h9, 8'hC3);
    bank(1'b1, 4'hA, 8'h0D);
    run_line(2'd2, 2'd1, 2'd0, 2'd0, 2);
    run_line(2'd3, 2'd0, 2'd0, 2'd3, 4);
    run_line(2'd2, 2'd1, 2'd0, 2'd0, 2);
  endtask

  task automatic test_clamp();
    bank(1'b1, 4'hC, 8'h4E);
    // nonzero target loaded before the clamp
    bank(1'b1, 4'hB, 8'h20);
    adc_code <= 10'h018;
    apb(1'b1, CTRL_CLAMP, 32'h00000001);
    wait_for(link.black_clamp_strobe, 1'b1);
    wait_for(clamp_engaged, 1'b1);
    `CHK("engage delay", 20, n)
    n = 0;
    while (offset_err === 12'h000 && n < 40)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK("offset error", 12'h008, offset_err)
    @(posedge pclk);
    adc_code <= 10'h000;
    wait_for(offset_pinned, 1'b1);
    `CHK("offset pinned", 1'b1, offset_pinned)
    `CHK("offset error", 12'h020, offset_err)
    apb(1'b1, CTRL_CLAMP, 32'h00000000);
    wait_for(clamp_engaged, 1'b0);
    `CHK("clamp release", 1'b0, clamp_engaged)
    expect_reg(4'h5, 8'h7F);
    // Request dropped at once: only the minimum hold keeps the strobe up
    apb(1'b1, CTRL_CLAMP, 32'h00000001);
    apb(1'b1, CTRL_CLAMP, 32'h00000000);
    wait_for(clamp_engaged, 1'b1);
    `CHK("short clamp engage", 1'b1, clamp_engaged)
    wait_for(link.black_clamp_strobe, 1'b0);
    `CHK("short clamp strobe", 1'b0, link.black_clamp_strobe)
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Generous against the under a thousand cycles the scenarios need
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    adc_code = 10'h000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    test_defaults();
    test_regs();
    test_pattern();
    test_clamp();
    test_done();
  end
endmodule
